// file: iorb_pkg.sv
// Purpose: Shared constants and types for the increment/OR/rotate/branch execution datapath
// Assumes: 8-bit data path, 7-bit file address, 13-bit program counter
// Notes:   Opcode selection is a small enum carried on the instruction port

package iorb_pkg;

  // Operation select
  typedef enum logic [2:0] {
    IORB_OP_NONE,
    IORB_OP_INCREMENT_SKIP_IF_ZERO,
    IORB_OP_INCREMENT_FILE,
    IORB_OP_UNCONDITIONAL_BRANCH,
    IORB_OP_OR_LITERAL,
    IORB_OP_OR_FILE,
    IORB_OP_ROTATE_LEFT_CARRY
  } iorb_op_e;

  // Widths
  localparam int IORB_DATA_W = 8;
  localparam int IORB_ADDR_W = 7;
  localparam int IORB_CNT_W  = 13;
  localparam int IORB_K11_W  = 11;

  // Field positions
  localparam int IORB_PAGE_LO    = 3;
  localparam int IORB_PAGE_HI    = 4;
  localparam int IORB_MSB        = 7;
  localparam int IORB_DEST_FILE  = 1;

  // Values after reset
  localparam logic [7:0]  IORB_W_RST     = 8'h00;
  localparam logic [12:0] IORB_CNT_RST   = 13'h0000;
  localparam logic        IORB_FLAG_RST  = 1'h0;
  localparam logic        IORB_PULSE_RST = 1'h0;
  localparam logic [6:0]  IORB_WADDR_RST = 7'h00;
  localparam logic [7:0]  IORB_WDATA_RST = 8'h00;

  // Instruction cycles taken by a branch or a skipped slot
  localparam int IORB_BRANCH_CYCLES = 2;

endpackage : iorb_pkg

// file: iorb_alu.sv
// Purpose: Combinational result and flag logic for the six supported operations
// Assumes: Operands are stable for the whole instruction cycle
// Notes:   Pure logic, no state

`timescale 1ns/1ps
`default_nettype none

module iorb_alu
  import iorb_pkg::*;
(
  // Operation and operands
  input  wire iorb_op_e   op,
  input  wire logic [7:0] w_val,
  input  wire logic [7:0] file_val,
  input  wire logic [7:0] literal,
  input  wire logic       carry_in,
  // Results
  output logic [7:0]      result,
  output logic            zero,
  output logic            carry_out
);

  wire [7:0] sum_inc  = file_val + 8'h01;
  wire [7:0] or_lit   = w_val | literal;
  wire [7:0] or_file  = w_val | file_val;
  wire [7:0] rot_left = {file_val[IORB_MSB-1:0], carry_in}; // Old carry into bit 0

  // Result selection per operation
  assign result = (op == IORB_OP_INCREMENT_SKIP_IF_ZERO) ? sum_inc :
                  (op == IORB_OP_INCREMENT_FILE)         ? sum_inc :
                  (op == IORB_OP_OR_LITERAL)             ? or_lit  :
                  (op == IORB_OP_OR_FILE)                ? or_file :
                  (op == IORB_OP_ROTATE_LEFT_CARRY)      ? rot_left :
                  8'h00;

  // Zero test on the full 8-bit result
  assign zero      = (result == 8'h00);
  // Old bit 7 becomes new carry
  assign carry_out = file_val[IORB_MSB];

endmodule // iorb_alu

`default_nettype wire

// file: iorb_exec.sv
// Purpose: Execution datapath for increment, OR, rotate-left and unconditional branch
// Assumes: One instruction presented per CLK cycle with INSTR_VALID; file data read combinationally
// Notes:   A skipped or branch-flushed slot ignores the instruction of the next cycle, valid or not,
//          and leaves the program counter where it is; NOP_SLOT marks that slot.
//          File write address and data are captured every cycle and only
//          qualified by FILE_WE, so a consumer must look at the strobe.
//          Working register and flags change only for the classes that own
//          them; branch and increment-skip leave both flags alone.
//          All outputs are registered; results appear one cycle after issue.

`timescale 1ns/1ps
`default_nettype none

module iorb_exec
  import iorb_pkg::*;
(
  // Clock and reset
  input  wire logic        CLK,
  input  wire logic        RST_B,
  // Instruction
  input  wire logic        INSTR_VALID,
  input  wire iorb_op_e    INSTR_OP,
  input  wire logic [6:0]  FILE_ADDR,
  input  wire logic        DEST_SEL,
  input  wire logic [7:0]  LITERAL,
  input  wire logic [10:0] BRANCH_TARGET,
  // File register read data and page latch
  input  wire logic [7:0]  FILE_RDATA,
  input  wire logic [7:0]  PROGRAM_PAGE_LATCH,
  // File register write port
  output logic             FILE_WE,
  output logic [6:0]       FILE_WADDR,
  output logic [7:0]       FILE_WDATA,
  // Architectural state
  output logic [7:0]       W_REG,
  output logic             ZERO_FLAG,
  output logic             CARRY_FLAG,
  output logic [12:0]      PROGRAM_COUNTER,
  output logic             COUNTER_LOADED,
  output logic             NOP_SLOT
);

  logic [7:0] alu_result;
  logic       alu_zero;
  logic       alu_carry;
  logic       flush;

  // Result and flag computation
  iorb_alu u_alu (
    .op        (INSTR_OP),
    .w_val     (W_REG),
    .file_val  (FILE_RDATA),
    .literal   (LITERAL),
    .carry_in  (CARRY_FLAG),
    .result    (alu_result),
    .zero      (alu_zero),
    .carry_out (alu_carry)
  );

  // Instruction decode; a flushed slot executes as a no-op
  wire go        = INSTR_VALID & ~flush;
  wire is_incsz  = go & (INSTR_OP == IORB_OP_INCREMENT_SKIP_IF_ZERO);
  wire is_inc    = go & (INSTR_OP == IORB_OP_INCREMENT_FILE);
  wire is_branch = go & (INSTR_OP == IORB_OP_UNCONDITIONAL_BRANCH);
  wire is_orlit  = go & (INSTR_OP == IORB_OP_OR_LITERAL);
  wire is_orf    = go & (INSTR_OP == IORB_OP_OR_FILE);
  wire is_rot    = go & (INSTR_OP == IORB_OP_ROTATE_LEFT_CARRY);
  wire file_op   = is_incsz | is_inc | is_orf | is_rot;

  // Destination routing
  wire to_file   = file_op & (DEST_SEL == 1'(IORB_DEST_FILE));
  wire to_w      = (file_op & (DEST_SEL != 1'(IORB_DEST_FILE))) | is_orlit;

  // Flag updates: zero for OR and plain increment only, carry for rotate only
  wire upd_zero  = is_inc | is_orlit | is_orf;
  wire upd_carry = is_rot;

  // Skip on zero result, none otherwise; branch always flushes one slot
  wire skip      = is_incsz & alu_zero;
  wire next_flush = skip | is_branch;

  // Counter sequencing: advances only for an executed instruction,
  // a branch replaces it outright, and the slot after a branch or taken
  // skip holds it, so the discarded word costs exactly one cycle
  // Branch target: page bits above the 11-bit immediate
  wire [12:0] branch_addr  = {PROGRAM_PAGE_LATCH[IORB_PAGE_HI:IORB_PAGE_LO], BRANCH_TARGET};
  // Sequential successor; the 13-bit counter wraps from the top to zero
  wire [12:0] seq_addr     = PROGRAM_COUNTER + 13'h0001;
  // An empty or flushed slot holds the counter
  wire [12:0] next_counter = is_branch ? branch_addr : (go ? seq_addr : PROGRAM_COUNTER);

  // Next architectural values; each register holds unless its own
  // instruction class writes it, so skip and branch never disturb flags
  wire [7:0]  next_w       = to_w ? alu_result : W_REG;
  wire        next_zero    = upd_zero ? alu_zero : ZERO_FLAG;
  wire        next_carry   = upd_carry ? alu_carry : CARRY_FLAG;

  // Next write-port values; address and data follow every cycle and are
  // only meaningful while the strobe is high, which keeps the path short
  wire        next_file_we = to_file;
  wire [6:0]  next_waddr   = FILE_ADDR;
  wire [7:0]  next_wdata   = alu_result;

  // Branch-taken pulse, one cycle after the branch executes
  wire        next_loaded  = is_branch;

  // Working register
  // Written by OR-literal and by file operations with destination bit 0
  // Rotate reads the registered carry, so back-to-back rotates chain
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      W_REG <= IORB_W_RST;
    end else begin
      W_REG <= next_w;
    end
  end

  // Zero flag
  // Updated only by OR and plain increment; others leave it alone
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      ZERO_FLAG <= IORB_FLAG_RST;
    end else begin
      ZERO_FLAG <= next_zero;
    end
  end

  // Carry flag
  // Updated only by rotate; old bit 7 of the operand moves in
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      CARRY_FLAG <= IORB_FLAG_RST;
    end else begin
      CARRY_FLAG <= next_carry;
    end
  end

  // File write strobe
  // One cycle per write; never raised for branch or OR-literal
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      FILE_WE <= IORB_PULSE_RST;
    end else begin
      FILE_WE <= next_file_we;
    end
  end

  // File write address
  // Captured every cycle; qualified by the strobe
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      FILE_WADDR <= IORB_WADDR_RST;
    end else begin
      FILE_WADDR <= next_waddr;
    end
  end

  // File write data
  // Captured every cycle; qualified by the strobe
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      FILE_WDATA <= IORB_WDATA_RST;
    end else begin
      FILE_WDATA <= next_wdata;
    end
  end

  // Program counter
  // Loaded by a branch, else advanced per executed instruction
  // A skipped word is never counted, so the flushed slot holds it
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      PROGRAM_COUNTER <= IORB_CNT_RST;
    end else begin
      PROGRAM_COUNTER <= next_counter;
    end
  end

  // Branch-loaded pulse
  // High for the one cycle in which the new counter value first shows
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      COUNTER_LOADED <= IORB_PULSE_RST;
    end else begin
      COUNTER_LOADED <= next_loaded;
    end
  end

  // No-op slot pulse
  // Marks the slot whose instruction is discarded
  // Stands one cycle, in step with the internal flush
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      NOP_SLOT <= IORB_PULSE_RST;
    end else begin
      NOP_SLOT <= next_flush;
    end
  end

  // Pending flush
  // Blocks decode of the slot after a branch or taken skip
  // Cleared after one slot even when that slot carries no instruction
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      flush <= IORB_PULSE_RST;
    end else begin
      flush <= next_flush;
    end
  end

endmodule // iorb_exec

`default_nettype wire

// file: iorb_exec_asserts.sv
// Purpose: Port-level assertions for the execution datapath
// Assumes: Taken means valid outside a flushed slot
// Notes:   Bound to every iorb_exec
`timescale 1ns/1ps
`default_nettype none
module iorb_exec_asserts
  import iorb_pkg::*;
(
  // Clock and reset
  input wire logic        CLK,
  input wire logic        RST_B,
  // Instruction
  input wire logic        INSTR_VALID,
  input wire iorb_op_e    INSTR_OP,
  input wire logic [6:0]  FILE_ADDR,
  input wire logic        DEST_SEL,
  input wire logic [7:0]  LITERAL,
  input wire logic [10:0] BRANCH_TARGET,
  input wire logic [7:0]  FILE_RDATA,
  input wire logic [7:0]  PROGRAM_PAGE_LATCH,
  // Outputs watched
  input wire logic        FILE_WE,
  input wire logic [6:0]  FILE_WADDR,
  input wire logic [7:0]  FILE_WDATA,
  input wire logic [7:0]  W_REG,
  input wire logic        ZERO_FLAG,
  input wire logic        CARRY_FLAG,
  input wire logic [12:0] PROGRAM_COUNTER,
  input wire logic        COUNTER_LOADED,
  input wire logic        NOP_SLOT
);
  // Decode of a taken instruction
  wire tk = INSTR_VALID && !NOP_SLOT;
  wire sk = tk && INSTR_OP == IORB_OP_INCREMENT_SKIP_IF_ZERO;
  wire ic = tk && INSTR_OP == IORB_OP_INCREMENT_FILE;
  wire of = tk && INSTR_OP == IORB_OP_OR_FILE;
  wire rl = tk && INSTR_OP == IORB_OP_ROTATE_LEFT_CARRY;
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_B);
  property p_skip; sk && FILE_RDATA == 8'hff |=> NOP_SLOT && $stable({ZERO_FLAG, CARRY_FLAG}); endproperty
  a_skip: assert property (p_skip) else $error("no skip slot");
  property p_run; sk && FILE_RDATA != 8'hff |=> !NOP_SLOT; endproperty
  a_run: assert property (p_run) else $error("bad skip");
  property p_dst; sk || ic || of || rl |=> FILE_WE == $past(DEST_SEL) && (!FILE_WE || FILE_WADDR == $past(FILE_ADDR));
  endproperty
  a_dst: assert property (p_dst) else $error("bad destination");
  property p_br; tk && INSTR_OP == IORB_OP_UNCONDITIONAL_BRANCH |=> COUNTER_LOADED && NOP_SLOT
    && PROGRAM_COUNTER == {$past(PROGRAM_PAGE_LATCH[4:3]), $past(BRANCH_TARGET)} ##1 !COUNTER_LOADED; endproperty
  a_br: assert property (p_br) else $error("bad branch");
  property p_orl; tk && INSTR_OP == IORB_OP_OR_LITERAL |=> W_REG == ($past(W_REG) | $past(LITERAL))
    && ZERO_FLAG == (W_REG == 8'h00); endproperty
  a_orl: assert property (p_orl) else $error("bad literal or");
  property p_inc; ic |=> !NOP_SLOT && ZERO_FLAG == ($past(FILE_RDATA) == 8'hff); endproperty
  a_inc: assert property (p_inc) else $error("bad increment");
  property p_orf; of |=> ZERO_FLAG == (($past(W_REG) | $past(FILE_RDATA)) == 8'h00); endproperty
  a_orf: assert property (p_orf) else $error("bad file or");
  property p_rot; rl |=> CARRY_FLAG == $past(FILE_RDATA[7]) && $stable(ZERO_FLAG); endproperty
  a_rot: assert property (p_rot) else $error("bad rotate");
endmodule // iorb_exec_asserts
bind iorb_exec iorb_exec_asserts chk (.*);
`default_nettype wire

// file: inc_or_rotate_branch_exec_test.sv
// Purpose: Random and corner test of the execution datapath
// Assumes: Bench drives file read data itself
// Notes:   Reference state held in w, z, c, exp_cnt
`timescale 1ns/1ps
`default_nettype none
module inc_or_rotate_branch_exec_test
  import iorb_pkg::*;
;
  logic CLK = 0, RST_B = 0, INSTR_VALID = 0, DEST_SEL = 0, FILE_WE, COUNTER_LOADED, NOP_SLOT, ZERO_FLAG, CARRY_FLAG;
  iorb_op_e INSTR_OP = IORB_OP_NONE;
  logic [6:0] FILE_ADDR = 7'h00, FILE_WADDR;
  logic [7:0] LITERAL = 8'h00, FILE_RDATA = 8'h00, PROGRAM_PAGE_LATCH = 8'h00, FILE_WDATA, W_REG, w = 8'h00;
  logic [10:0] BRANCH_TARGET = 11'h000;
  logic [12:0] PROGRAM_COUNTER, exp_cnt = 13'h0000;
  logic z = 0, c = 0;
  int seed = 91772, err_total = 0, num_checks = 0;
  iorb_exec dut (.*);
  initial forever #10 CLK = ~CLK;
  // Compare seen against expected
  task chk(logic [31:0] g, e);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %0t saw %h want %h", $time, g, e);
    end
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Carry and result of one operation
  function automatic logic [8:0] calc(iorb_op_e o, logic [7:0] f);
    case (o)
      IORB_OP_OR_LITERAL: calc = {c, w | LITERAL};
      IORB_OP_OR_FILE: calc = {c, w | f};
      IORB_OP_ROTATE_LEFT_CARRY: calc = {f, c};
      default: calc = {c, f + 8'h01};
    endcase
  endfunction
  // Present one instruction, then check state and the flushed slot
  task run(iorb_op_e o, logic dd, logic [7:0] f, k);
    logic fo, br, nop;
    logic [8:0] x;
    INSTR_VALID = 1'b1;
    INSTR_OP = o;
    DEST_SEL = dd;
    FILE_RDATA = f;
    LITERAL = k;
    {FILE_ADDR, BRANCH_TARGET, PROGRAM_PAGE_LATCH} = 26'($random(seed));
    x = calc(o, f);
    br = o == IORB_OP_UNCONDITIONAL_BRANCH;
    nop = br || (o == IORB_OP_INCREMENT_SKIP_IF_ZERO && x[7:0] == 8'h00);
    fo = !br && o != IORB_OP_OR_LITERAL && o != IORB_OP_INCREMENT_SKIP_IF_ZERO;
    exp_cnt = br ? {PROGRAM_PAGE_LATCH[4:3], BRANCH_TARGET} : exp_cnt + 13'h0001;
    if (o == IORB_OP_OR_LITERAL || ((fo || !nop && o == IORB_OP_INCREMENT_SKIP_IF_ZERO || nop && !br) && !dd)) w = x[7:0];
    if (fo && o != IORB_OP_ROTATE_LEFT_CARRY || o == IORB_OP_OR_LITERAL) z = x[7:0] == 8'h00;
    c = x[8];
    fo = (fo || o == IORB_OP_INCREMENT_SKIP_IF_ZERO) && dd;
    @(posedge CLK) #1;
    chk({W_REG, ZERO_FLAG, CARRY_FLAG}, {w, z, c});
    chk(PROGRAM_COUNTER, exp_cnt);
    chk({FILE_WE, COUNTER_LOADED, NOP_SLOT}, {fo, br, nop});
    if (fo) chk({FILE_WADDR, FILE_WDATA}, {FILE_ADDR, x[7:0]});
    if (nop) begin
      INSTR_OP = IORB_OP_OR_LITERAL;
      LITERAL = 8'hff;
      @(posedge CLK) #1;
      chk({W_REG, ZERO_FLAG, CARRY_FLAG, PROGRAM_COUNTER, NOP_SLOT, FILE_WE, COUNTER_LOADED},
          {w, z, c, exp_cnt, 3'h0});
    end
  endtask
  initial begin
    repeat (3) @(posedge CLK);
    #1 RST_B = 1'b1;
    run(IORB_OP_OR_LITERAL, 1'b0, 8'h00, 8'h00);
    run(IORB_OP_INCREMENT_SKIP_IF_ZERO, 1'b0, 8'hff, 8'h00);
    run(IORB_OP_UNCONDITIONAL_BRANCH, 1'b0, 8'h00, 8'h00);
    run(IORB_OP_ROTATE_LEFT_CARRY, 1'b0, 8'h80, 8'h00);
    run(IORB_OP_INCREMENT_FILE, 1'b1, 8'hff, 8'h00);
    $display("corner cases done");
    repeat (400) run(iorb_op_e'(3'(1 + {$random(seed)} % 6)), 1'($random(seed)),
      (($random(seed) & 3) == 0) ? 8'hff : 8'($random(seed)), 8'($random(seed)));
    $display("random cases done");
    INSTR_VALID = 1'b0;
    end_sim;
  end
  // Guard against a hang
  initial begin
    #100000;
    err_total++;
    end_sim;
  end
endmodule // inc_or_rotate_branch_exec_test
`default_nettype wire
